// ### logic/ppcf_defines.vh
// Register offsets, field positions, reset values and timing constants for the pad configuration block
`ifndef PPCF_DEFINES_VH
`define PPCF_DEFINES_VH

// ----------------------------------------------------------------
// Register byte addresses (full system address and low offset)
// ----------------------------------------------------------------
`define PPCF_PIN_A_ADDR      32'h40044084
`define PPCF_PIN_B_ADDR      32'h40044088
`define PPCF_BASE_ADDR       32'h40044080
`define PPCF_PIN_A_OFS       12'h084
`define PPCF_PIN_B_OFS       12'h088

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PPCF_PULL_LSB        3
`define PPCF_PULL_MSB        4
`define PPCF_HYS_BIT         5
`define PPCF_INV_BIT         6
`define PPCF_RSVD_LSB        7
`define PPCF_RSVD_MSB        9
`define PPCF_POD_BIT         10
`define PPCF_SMODE_LSB       11
`define PPCF_SMODE_MSB       12
`define PPCF_CDIV_LSB        13
`define PPCF_CDIV_MSB        15

// ----------------------------------------------------------------
// Reset values and encodings
// ----------------------------------------------------------------
`define PPCF_HYS_RST         1'h1
`define PPCF_INV_RST         1'h0
`define PPCF_RSVD_RST        3'h1
`define PPCF_POD_RST         1'h0
`define PPCF_SMODE_RST       2'h0
`define PPCF_SMODE_BYPASS    2'h0
`define PPCF_CDIV_RST        3'h0
`define PPCF_CDIV_RSVD       3'h7
`define PPCF_PULL_REPEATER   2'h3
`define PPCF_NUM_DIV         7

// ----------------------------------------------------------------
// Timing: default filter divider ratios, in pclk cycles
// ----------------------------------------------------------------
`define PPCF_DIV0_CYCLES     16'h0001
`define PPCF_DIV_STEP_CYCLES 16'h0002

`endif

// ### logic/ppcf_glitch_filter.v
// Digital glitch filter for one pad input, stepped by a sample enable
`timescale 1ns/1ps
`include "ppcf_defines.vh"

module ppcf_glitch_filter (
  // Clock and reset
  input  wire       pclk,
  input  wire       presetn,
  // Control
  input  wire       sample_en,
  input  wire [1:0] sample_mode,
  // Data
  input  wire       din,
  output reg        dout
);

  reg  [1:0] run_reg;
  reg        cand_reg;

  // ----------------------------------------------------------------
  // Filter state
  // ----------------------------------------------------------------
  // A new level is accepted only after sample_mode equal samples in a row;
  // bypass tracks din every pclk so that mode switches never strand dout.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dout     <= 1'b0;
      run_reg  <= 2'h0;
      cand_reg <= 1'b0;
    end else if (sample_mode == `PPCF_SMODE_BYPASS) begin
      dout     <= din;
      run_reg  <= 2'h0;
      cand_reg <= din;
    end else if (sample_en) begin
      if (din == dout) begin
        run_reg  <= 2'h0;
        cand_reg <= din;
      end else if (din != cand_reg || run_reg == 2'h0) begin
        cand_reg <= din;
        if (sample_mode == 2'h1) begin
          dout    <= din;
          run_reg <= 2'h0;
        end else begin
          run_reg <= 2'h1;
        end
      end else if (run_reg + 2'h1 >= sample_mode) begin
        dout    <= din;
        run_reg <= 2'h0;
      end else begin
        run_reg <= run_reg + 2'h1;
      end
    end
  end

endmodule // ppcf_glitch_filter

// ### logic/ppcf_pad_config.v
// Pad configuration and input filter block for two pins, with APB register access
`timescale 1ns/1ps
`include "ppcf_defines.vh"

// Operation
// - Bits 4:3 choose pull mode; reset value comes from nonvolatile boot configuration.
// - Bit 6 inverts the pin input when set; resets to zero.
// - Bit 10 selects pseudo open-drain output instead of push-pull; resets to zero.
// - Bits 12:11 pick filter mode; zero bypasses the filter and is reset.
// - Modes one to three reject pulses shorter than one, two, three filter clocks.
// - Bits 15:13 pick one of seven filter clock dividers; resets to zero.
// - Two identical pin registers sit at consecutive word addresses.
module ppcf_pad_config #(
  parameter [15:0] DIV0_CYCLES     = `PPCF_DIV0_CYCLES,
  parameter [15:0] DIV_STEP_CYCLES = `PPCF_DIV_STEP_CYCLES
) (
  // APB clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Nonvolatile boot configuration, pull mode straps per pin
  input  wire [1:0]  boot_pull_a,
  input  wire [1:0]  boot_pull_b,
  // Pin A pad side
  input  wire        pin_a_in,
  input  wire        pin_a_out,
  output reg         pin_a_oe_n,
  output reg  [1:0]  pin_a_pull,
  output reg         pin_a_hysteresis_enable,
  output reg         pin_a_filtered,
  // Pin B pad side
  input  wire        pin_b_in,
  input  wire        pin_b_out,
  output reg         pin_b_oe_n,
  output reg  [1:0]  pin_b_pull,
  output reg         pin_b_hysteresis_enable,
  output reg         pin_b_filtered,
  // Peripheral output enables towards the pads
  input  wire        pin_a_drive_en,
  input  wire        pin_b_drive_en
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  reg  [15:0] cfg_a_reg;
  reg  [15:0] cfg_b_reg;
  reg         strap_done_reg;
  reg  [1:0]  sync_a_reg;
  reg  [1:0]  sync_b_reg;
  reg  [15:0] div_cnt_reg [0:`PPCF_NUM_DIV-1];
  reg  [`PPCF_NUM_DIV-1:0] div_tick_reg;
  wire        filt_a;
  wire        filt_b;
  wire        tick_a;
  wire        tick_b;
  wire        sel_a;
  wire        sel_b;
  wire        wr_acc;
  wire        rd_acc;
  integer     i;

  // Reset image of one config register with a given pull mode
  function [15:0] cfg_reset;
    input [1:0] pull;
    begin
      cfg_reset = 16'h0000;
      cfg_reset[`PPCF_PULL_MSB:`PPCF_PULL_LSB] = pull;
      cfg_reset[`PPCF_HYS_BIT] = `PPCF_HYS_RST;
      cfg_reset[`PPCF_INV_BIT] = `PPCF_INV_RST;
      cfg_reset[`PPCF_RSVD_MSB:`PPCF_RSVD_LSB] = `PPCF_RSVD_RST;
      cfg_reset[`PPCF_POD_BIT] = `PPCF_POD_RST;
      cfg_reset[`PPCF_SMODE_MSB:`PPCF_SMODE_LSB] = `PPCF_SMODE_RST;
      cfg_reset[`PPCF_CDIV_MSB:`PPCF_CDIV_LSB] = `PPCF_CDIV_RST;
    end
  endfunction

  // Writable image: reserved low bits stay zero, 9:7 keep their pattern
  function [15:0] cfg_write;
    input [31:0] wdata;
    begin
      cfg_write = wdata[15:0];
      cfg_write[2:0] = 3'h0;
      cfg_write[`PPCF_RSVD_MSB:`PPCF_RSVD_LSB] = `PPCF_RSVD_RST;
    end
  endfunction

  // Divider tick chosen by a select field; reserved code never ticks
  function div_pick;
    input [2:0] sel;
    input [`PPCF_NUM_DIV-1:0] ticks;
    begin
      if (sel == `PPCF_CDIV_RSVD)
        div_pick = 1'b0;
      else
        div_pick = ticks[sel];
    end
  endfunction

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign sel_a  = (paddr == `PPCF_PIN_A_ADDR);
  assign sel_b  = (paddr == `PPCF_PIN_B_ADDR);
  assign wr_acc = psel && penable && pready && pwrite;
  assign rd_acc = psel && !penable && !pwrite;

  // ----------------------------------------------------------------
  // Config registers
  // ----------------------------------------------------------------
  // Straps are caught one edge after reset release, never under reset.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_a_reg      <= cfg_reset(2'h0);
      cfg_b_reg      <= cfg_reset(2'h0);
      strap_done_reg <= 1'b0;
    end else if (!strap_done_reg) begin
      strap_done_reg <= 1'b1;
      cfg_a_reg[`PPCF_PULL_MSB:`PPCF_PULL_LSB] <= boot_pull_a;
      cfg_b_reg[`PPCF_PULL_MSB:`PPCF_PULL_LSB] <= boot_pull_b;
    end else if (wr_acc) begin
      if (sel_a)
        cfg_a_reg <= cfg_write(pwdata);
      if (sel_b)
        cfg_b_reg <= cfg_write(pwdata);
    end
  end

  // ----------------------------------------------------------------
  // APB answer
  // ----------------------------------------------------------------
  // No wait state: data is registered in setup, pready rises in access.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !(sel_a || sel_b);
      if (rd_acc) begin
        if (sel_a)
          prdata <= {16'h0000, cfg_a_reg};
        else if (sel_b)
          prdata <= {16'h0000, cfg_b_reg};
        else
          prdata <= 32'h00000000;
      end
    end
  end

  // ----------------------------------------------------------------
  // Filter clock dividers
  // ----------------------------------------------------------------
  // Divider k ticks once every DIV0 + k*STEP pclk cycles.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (i = 0; i < `PPCF_NUM_DIV; i = i + 1)
        div_cnt_reg[i] <= 16'h0000;
      div_tick_reg <= {`PPCF_NUM_DIV{1'b0}};
    end else begin
      for (i = 0; i < `PPCF_NUM_DIV; i = i + 1) begin
        if (div_cnt_reg[i] + 16'h0001 >= DIV0_CYCLES + DIV_STEP_CYCLES * i[15:0]) begin
          div_cnt_reg[i]  <= 16'h0000;
          div_tick_reg[i] <= 1'b1;
        end else begin
          div_cnt_reg[i]  <= div_cnt_reg[i] + 16'h0001;
          div_tick_reg[i] <= 1'b0;
        end
      end
    end
  end

  assign tick_a = div_pick(cfg_a_reg[`PPCF_CDIV_MSB:`PPCF_CDIV_LSB], div_tick_reg);
  assign tick_b = div_pick(cfg_b_reg[`PPCF_CDIV_MSB:`PPCF_CDIV_LSB], div_tick_reg);

  // ----------------------------------------------------------------
  // Pin input synchronisers with polarity
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a_reg <= 2'h0;
      sync_b_reg <= 2'h0;
    end else begin
      sync_a_reg <= {sync_a_reg[0], pin_a_in};
      sync_b_reg <= {sync_b_reg[0], pin_b_in};
    end
  end

  // Inversion sits after the second stage so the first stays clean
  ppcf_glitch_filter u_filt_a (
    .pclk        (pclk),
    .presetn     (presetn),
    .sample_en   (tick_a),
    .sample_mode (cfg_a_reg[`PPCF_SMODE_MSB:`PPCF_SMODE_LSB]),
    .din         (sync_a_reg[1] ^ cfg_a_reg[`PPCF_INV_BIT]),
    .dout        (filt_a)
  );

  ppcf_glitch_filter u_filt_b (
    .pclk        (pclk),
    .presetn     (presetn),
    .sample_en   (tick_b),
    .sample_mode (cfg_b_reg[`PPCF_SMODE_MSB:`PPCF_SMODE_LSB]),
    .din         (sync_b_reg[1] ^ cfg_b_reg[`PPCF_INV_BIT]),
    .dout        (filt_b)
  );

  // ----------------------------------------------------------------
  // Pad control outputs
  // ----------------------------------------------------------------
  // Pseudo open-drain only releases on a high level; no true drain cell.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_a_oe_n              <= 1'b1;
      pin_b_oe_n              <= 1'b1;
      pin_a_pull              <= 2'h0;
      pin_b_pull              <= 2'h0;
      pin_a_hysteresis_enable <= `PPCF_HYS_RST;
      pin_b_hysteresis_enable <= `PPCF_HYS_RST;
      pin_a_filtered          <= 1'b0;
      pin_b_filtered          <= 1'b0;
    end else begin
      pin_a_oe_n <= !(pin_a_drive_en && !(cfg_a_reg[`PPCF_POD_BIT] && pin_a_out));
      pin_b_oe_n <= !(pin_b_drive_en && !(cfg_b_reg[`PPCF_POD_BIT] && pin_b_out));
      pin_a_pull <= cfg_a_reg[`PPCF_PULL_MSB:`PPCF_PULL_LSB];
      pin_b_pull <= cfg_b_reg[`PPCF_PULL_MSB:`PPCF_PULL_LSB];
      pin_a_hysteresis_enable <= cfg_a_reg[`PPCF_HYS_BIT];
      pin_b_hysteresis_enable <= cfg_b_reg[`PPCF_HYS_BIT];
      pin_a_filtered <= filt_a;
      pin_b_filtered <= filt_b;
    end
  end

endmodule // ppcf_pad_config

// ### verification/ppcf_monitor.sv
// Port-level assertions for the pad configuration block
`timescale 1ns/1ps
`include "ppcf_defines.vh"
module ppcf_monitor (
  // APB side
  input logic        pclk, presetn, psel, penable, pwrite, pready, pslverr,
  input logic [31:0] paddr, prdata,
  // Pin A pad side
  input logic        pin_a_oe_n, pin_a_drive_en,
  input logic [1:0]  pin_a_pull
);
  logic [2:0] rst_age;
  wire setup  = psel && !penable;
  wire acc_wr = psel && penable && pwrite && pready && paddr == `PPCF_PIN_A_ADDR;
  wire mapped = paddr == `PPCF_PIN_A_ADDR || paddr == `PPCF_PIN_B_ADDR;
  // Edges since reset release; the strap load lands in this window
  always @(posedge pclk or negedge presetn)
    if (!presetn) rst_age <= 3'h0;
    else if (rst_age != 3'h7) rst_age <= rst_age + 3'h1;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_answer_next: assert property (setup |=> pready) else $error("no answer after setup");
  chk_ready_pulse: assert property (pready |=> !pready) else $error("ready longer than one cycle");
  chk_err_unmapped: assert property (setup && !mapped |=> pslverr && pready)
    else $error("unmapped access not refused");
  chk_ok_mapped: assert property (setup && mapped |=> !pslverr) else $error("mapped access refused");
  chk_err_qualified: assert property (pslverr |-> pready) else $error("error without ready");
  chk_rdata_hold: assert property ($changed(prdata) |-> $past(setup && !pwrite))
    else $error("read data moved without read");
  chk_drive_cause: assert property (!pin_a_oe_n |-> $past(pin_a_drive_en))
    else $error("pad driven without request");
  chk_pull_cause: assert property ($changed(pin_a_pull) |-> $past(acc_wr, 2) || rst_age < 3'h4)
    else $error("pull moved without write");
endmodule // ppcf_monitor

// ### verification/ppcf_pin_model.sv
// External pin model: the far-side source, overridden while the pad drives
`timescale 1ns/1ps
module ppcf_pin_model (
  // Pad drive from the block and peripherals
  input  logic pin_a_oe_n, pin_b_oe_n, pin_a_out, pin_b_out,
  // Pad levels seen by the block
  output logic pin_a_in, pin_b_in
);
  logic ext_a = 1'b0;
  logic ext_b = 1'b0;
  // Pad drive wins; otherwise the external source sets the level
  assign pin_a_in = !pin_a_oe_n ? pin_a_out : ext_a;
  assign pin_b_in = !pin_b_oe_n ? pin_b_out : ext_b;
endmodule // ppcf_pin_model

// ### verification/testbench.sv
// Self-checking bench for the pad configuration block
`timescale 1ns/1ps
`include "ppcf_defines.vh"
module testbench;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, pin_a_in, pin_b_in, pin_a_oe_n, pin_b_oe_n, er;
  logic pin_a_hysteresis_enable, pin_b_hysteresis_enable, pin_a_filtered, pin_b_filtered;
  logic [1:0] pin_a_pull, pin_b_pull, boot_pull_a = 2'h2, boot_pull_b = 2'h1;
  logic pin_a_out = 1'b0, pin_b_out = 1'b0, pin_a_drive_en = 1'b0, pin_b_drive_en = 1'b0;
  int failures = 0, checks_done = 0, cycles = 0;
  localparam logic [31:0] A = `PPCF_PIN_A_ADDR, B = `PPCF_PIN_B_ADDR;
  ppcf_pad_config dut (.*);
  ppcf_pin_model model (.*);
  always #5 pclk = ~pclk;
  // Cycle ceiling against a hung handshake
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures = failures + 1;
      end_sim;
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic end_sim;
    if (failures == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // One APB transfer; an idle edge follows so releases never collide
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    // Waits as long as the slave needs; only the cycle ceiling ends a hang
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rdchk(input string n, input logic [31:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, e, rd);
  endtask
  task automatic t_regs;
    rdchk("cfg_a", A, 32'h000000b0);
    rdchk("cfg_b", B, 32'h000000a8);
    chk("hys_a", 1, pin_a_hysteresis_enable);
    apb(1'b1, A, 32'h0000dcf8);
    rdchk("cfg_a", A, 32'h0000dcf8);
    rdchk("cfg_b", B, 32'h000000a8);
    chk("pull_a", 3, pin_a_pull);
    for (int p = 0; p < 4; p++) begin
      apb(1'b1, B, 32'h80 | p << 3);
      cyc(1);
      chk("pull_b", p, pin_b_pull);
      chk("hys_b", 0, pin_b_hysteresis_enable);
    end
    rdchk("unmapped", 32'h4004408c, 32'h0);
    chk("err", 1, er);
    apb(1'b1, 32'h40044080, 32'h90);
    chk("err", 1, er);
    rdchk("cfg_a", A, 32'h0000dcf8);
    apb(1'b1, A, 32'h80);
  endtask
  task automatic t_drive;
    pin_a_drive_en <= 1'b1; pin_a_out <= 1'b1; cyc(3);
    chk("oe_pp", 0, pin_a_oe_n);
    apb(1'b1, A, 32'h480); cyc(2);
    chk("oe_pod_hi", 1, pin_a_oe_n);
    pin_a_out <= 1'b0; cyc(3);
    chk("oe_pod_lo", 0, pin_a_oe_n);
    pin_a_drive_en <= 1'b0; cyc(3);
    chk("oe_off", 1, pin_a_oe_n);
    apb(1'b1, A, 32'h80);
  endtask
  // Pin B pad drive and input path, so its outputs are judged too
  task automatic t_pin_b;
    pin_b_drive_en <= 1'b1; pin_b_out <= 1'b1; cyc(3);
    chk("oe_b_pp", 0, pin_b_oe_n);
    apb(1'b1, B, 32'h480); cyc(2);
    chk("oe_b_pod_hi", 1, pin_b_oe_n);
    pin_b_drive_en <= 1'b0; pin_b_out <= 1'b0; model.ext_b <= 1'b1; cyc(6);
    chk("bypass_b", 1, pin_b_filtered);
    apb(1'b1, B, 32'hc0); cyc(6);
    chk("inverted_b", 0, pin_b_filtered);
    model.ext_b <= 1'b0; apb(1'b1, B, 32'h80);
  endtask
  task automatic t_invert;
    model.ext_a <= 1'b1; cyc(6);
    chk("bypass", 1, pin_a_filtered);
    apb(1'b1, A, 32'hc0); cyc(6);
    chk("inverted", 0, pin_a_filtered);
    model.ext_a <= 1'b0; cyc(6);
    chk("inverted", 1, pin_a_filtered);
    apb(1'b1, A, 32'h80); cyc(6);
    chk("plain", 0, pin_a_filtered);
  endtask
  // Mode m on divider k: for m above 1 a short pulse dies, a held level passes in time
  task automatic filt(input int m, input int k);
    int p, n;
    p = 1 + 2 * k;
    n = 0;
    apb(1'b1, A, 32'h80 | m << 11 | k << 13);
    cyc(20);
    if (m > 1) begin
      model.ext_a <= 1'b1; cyc((m - 1) * p);
      model.ext_a <= 1'b0;
      repeat (30) begin
        @(posedge pclk);
        if (pin_a_filtered !== 1'b0) n = 1;
      end
      chk("pulse_kept", 0, n);
    end
    n = 0;
    model.ext_a <= 1'b1;
    do @(posedge pclk); while (pin_a_filtered !== 1'b1 && ++n < 200);
    chk("too_late", 1, n <= m * p + 6);
    chk("too_early", 1, n >= (m - 1) * p + 3);
    model.ext_a <= 1'b0; cyc(m * p + 10);
    chk("released", 0, pin_a_filtered);
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    cyc(2);
    t_regs;
    t_drive;
    t_pin_b;
    t_invert;
    for (int m = 1; m < 4; m++) filt(m, 2);
    for (int k = 0; k < 7; k++) filt(2, k);
    end_sim;
  end
endmodule // testbench
bind ppcf_pad_config ppcf_monitor mon (.*);
